// [setting_area_exchange_loader.sv]
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module setting_area_exchange_loader (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic [6:0] unit_number,
	input wire logic [95:0] restart_bits,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	output logic setting_error_lamp,
	output logic [15:0] error_offset
);
	import loader_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		loader_pkg::fsm_type fsm;
		logic [6:0] ofs;
		logic [6:0] unit;
		logic [15:0] base;
		logic restart_prev;
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic lamp;
		logic [15:0] err_ofs;
		logic [15:0] limit;
		logic [3:0] status;
		logic [3:0] mask;
		logic a_valid;
		logic [11:0] a_addr;
		logic a_write;
		logic a_win;
		logic [31:0] rdata;
	} loader_state_type;

	loader_state_type r_reg;
	loader_state_type r_next;

	store_if st ();

	settings_store store_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.port(st)
	);

	////////////////////////////////////////////////////////////////////////////

	logic restart_now;
	logic take;
	logic [3:0] set_bits;
	logic [3:0] clr_bits;
	logic [6:0] unit_pick;
	logic bad_word;

	assign restart_now = restart_bits[r_reg.unit] && !r_reg.restart_prev;
	assign take = hsel && htrans[1] && hready;
	assign bad_word = mem_rdata > r_reg.limit;
	assign unit_pick = (unit_number > UNIT_MAX) ? UNIT_MAX : unit_number;

	always_comb begin
		r_next = r_reg;
		set_bits = 4'h0;
		clr_bits = 4'h0;
		st.we = 1'b0;
		st.waddr = r_reg.ofs;
		st.wdata = mem_rdata;
		st.raddr = haddr[8:2];
		r_next.restart_prev = restart_bits[r_reg.unit];
		r_next.a_valid = take;

		unique case (r_reg.fsm)
			S_START: begin
				r_next.unit = unit_pick;
				r_next.restart_prev = restart_bits[unit_pick];
				r_next.base = BASE_ADDR + 16'({9'h000, unit_pick} * BLOCK_WORDS);
				r_next.ofs = OFS_CMD;
				r_next.fsm = S_CMD;
			end
			S_CMD: begin
				if (!r_reg.req) begin
					r_next.req = 1'b1;
					r_next.we = 1'b0;
					r_next.addr = r_reg.base + {9'h000, OFS_CMD};
				end else if (mem_ack) begin
					r_next.req = 1'b0;
					r_next.ofs = OFS_G1_FIRST;
					if (mem_rdata == CMD_UPLOAD) begin
						r_next.fsm = S_UPLOAD;
					end else begin
						r_next.fsm = S_LOAD;
					end
				end
			end
			S_UPLOAD: begin
				if (!r_reg.req) begin
					r_next.req = 1'b1;
					r_next.we = 1'b1;
					r_next.addr = r_reg.base + {9'h000, r_reg.ofs};
					r_next.wdata = DEFAULT_WORD;
				end else if (mem_ack) begin
					// defaults also become the working set
					r_next.req = 1'b0;
					st.we = 1'b1;
					st.wdata = DEFAULT_WORD;
					if (r_reg.ofs == OFS_LAST) begin
						r_next.ofs = OFS_CMD;
						r_next.fsm = S_CLEAR;
					end else begin
						r_next.ofs = r_reg.ofs + 7'h01;
					end
				end
			end
			S_CLEAR: begin
				if (!r_reg.req) begin
					r_next.req = 1'b1;
					r_next.we = 1'b1;
					r_next.addr = r_reg.base + {9'h000, OFS_CMD};
					r_next.wdata = CMD_CLEAR;
				end else if (mem_ack) begin
					r_next.req = 1'b0;
					set_bits[ST_UPLOAD] = 1'b1;
					r_next.ofs = OFS_G1_FIRST;
					r_next.fsm = S_REFRESH;
				end
			end
			S_LOAD: begin
				if (!r_reg.req) begin
					r_next.req = 1'b1;
					r_next.we = r_reg.ofs == OFS_ERR;
					r_next.addr = r_reg.base + {9'h000, r_reg.ofs};
					r_next.wdata = r_reg.err_ofs;
				end else if (mem_ack) begin
					r_next.req = 1'b0;
					if (r_reg.ofs == OFS_ERR) begin
						// error offset stored in the display word
						set_bits[ST_LOAD] = 1'b1;
						r_next.ofs = OFS_G1_FIRST;
						r_next.fsm = S_REFRESH;
					end else begin
						// second group read only here, once per start
						st.we = 1'b1;
						// second group errors caught during start load
						if (bad_word && !r_reg.lamp) begin
							r_next.lamp = 1'b1;
							r_next.err_ofs = {9'h000, r_reg.ofs};
							set_bits[ST_ERROR] = 1'b1;
						end
						r_next.ofs = (r_reg.ofs == OFS_G2_LAST) ? OFS_ERR : r_reg.ofs + 7'h01;
					end
				end
			end
			S_REFRESH: begin
				// endless group one loop, no mode input gates it
				if (!r_reg.req) begin
					r_next.req = 1'b1;
					r_next.we = r_reg.ofs == OFS_ERR;
					r_next.addr = r_reg.base + {9'h000, r_reg.ofs};
					r_next.wdata = r_reg.err_ofs;
				end else if (mem_ack) begin
					r_next.req = 1'b0;
					if (r_reg.ofs == OFS_ERR) begin
						r_next.ofs = OFS_G1_FIRST;
					end else begin
						st.we = 1'b1;
						if (bad_word && !r_reg.lamp) begin
							r_next.lamp = 1'b1;
							r_next.err_ofs = {9'h000, r_reg.ofs};
							set_bits[ST_ERROR] = 1'b1;
						end
						if (r_reg.ofs != OFS_G1_LAST) begin
							r_next.ofs = r_reg.ofs + 7'h01;
						end else if (r_reg.lamp || (bad_word && !r_reg.lamp)) begin
							// publish the offset once per pass while lit
							r_next.ofs = OFS_ERR;
						end else begin
							r_next.ofs = OFS_G1_FIRST;
						end
					end
				end
			end
		endcase

		if (restart_now) begin
			r_next.fsm = S_START;
			r_next.req = 1'b0;
			r_next.we = 1'b0;
			r_next.lamp = 1'b0;
			r_next.err_ofs = 16'h0000;
			set_bits[ST_RESTART] = 1'b1;
		end

		// register writes land in the data phase
		if (r_reg.a_valid && r_reg.a_write) begin
			unique case (r_reg.a_addr)
				REG_LIMIT: r_next.limit = hwdata[15:0];
				REG_STATUS: clr_bits = hwdata[3:0];
				REG_MASK: r_next.mask = hwdata[3:0];
				default: begin
				end
			endcase
		end
		// a new event beats a write-one clear in the same cycle
		r_next.status = (r_reg.status & ~clr_bits) | set_bits;

		// read data taken from the updated copy so write then read is coherent
		r_next.a_addr = haddr[11:0];
		r_next.a_write = hwrite;
		r_next.a_win = take && !hwrite && haddr[11:9] == WIN_SEL && haddr[8:2] <= OFS_LAST;
		r_next.rdata = 32'h0000_0000;
		if (take && !hwrite) begin
			unique case (haddr[11:0])
				REG_LIMIT: r_next.rdata = {16'h0000, r_next.limit};
				REG_STATUS: r_next.rdata = {28'h0000000, r_next.status};
				REG_MASK: r_next.rdata = {28'h0000000, r_next.mask};
				REG_STATE: begin
					r_next.rdata[15:0] = r_next.err_ofs;
					r_next.rdata[STATE_LAMP] = r_next.lamp;
					r_next.rdata[STATE_FSM +: 6] = r_next.fsm;
					r_next.rdata[STATE_UNIT +: 7] = r_next.unit;
				end
				default: r_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg.fsm <= S_START;
			r_reg.ofs <= OFS_CMD;
			r_reg.unit <= 7'h00;
			r_reg.base <= BASE_ADDR;
			r_reg.restart_prev <= 1'b0;
			r_reg.req <= 1'b0;
			r_reg.we <= 1'b0;
			r_reg.addr <= 16'h0000;
			r_reg.wdata <= 16'h0000;
			r_reg.lamp <= 1'b0;
			r_reg.err_ofs <= 16'h0000;
			r_reg.limit <= LIMIT_RST;
			r_reg.status <= STATUS_RST;
			r_reg.mask <= MASK_RST;
			r_reg.a_valid <= 1'b0;
			r_reg.a_addr <= 12'h000;
			r_reg.a_write <= 1'b0;
			r_reg.a_win <= 1'b0;
			r_reg.rdata <= 32'h0000_0000;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// zero wait state slave, every answer OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.a_win ? {16'h0000, st.rdata} : r_reg.rdata;
	assign irq = |(r_reg.status & r_reg.mask);

	assign mem_req = r_reg.req;
	assign mem_we = r_reg.we;
	assign mem_addr = r_reg.addr;
	assign mem_wdata = r_reg.wdata;
	assign setting_error_lamp = r_reg.lamp;
	assign error_offset = r_reg.err_ofs;

endmodule : setting_area_exchange_loader

// [loader_pkg.sv]
package loader_pkg;

	// host side parameter memory block
	localparam logic [15:0] CMD_UPLOAD = 16'h3039;
	localparam logic [15:0] CMD_CLEAR = 16'h0000;
	localparam logic [15:0] BASE_ADDR = 16'h4e20;
	localparam logic [15:0] BLOCK_WORDS = 16'h0064;
	localparam logic [6:0] UNIT_MAX = 7'h5f;
	localparam int STORE_WORDS = 100;

	// word offsets inside the block
	localparam logic [6:0] OFS_CMD = 7'h00;
	localparam logic [6:0] OFS_G1_FIRST = 7'h01;
	localparam logic [6:0] OFS_G1_LAST = 7'h27;
	localparam logic [6:0] OFS_G2_FIRST = 7'h28;
	localparam logic [6:0] OFS_G2_LAST = 7'h59;
	localparam logic [6:0] OFS_ERR = 7'h5a;
	localparam logic [6:0] OFS_LAST = 7'h63;

	// default setting uploaded to the host for every word after the command word
	localparam logic [15:0] DEFAULT_WORD = 16'h0000;
	localparam logic [15:0] LIMIT_RST = 16'h7fff;

	// register map, byte addresses
	localparam logic [11:0] REG_LIMIT = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_MASK = 12'h008;
	localparam logic [11:0] REG_STATE = 12'h00c;
	localparam logic [2:0] WIN_SEL = 3'h1;

	// status and mask bit positions
	localparam int STATUS_W = 4;
	localparam int ST_UPLOAD = 0;
	localparam int ST_LOAD = 1;
	localparam int ST_ERROR = 2;
	localparam int ST_RESTART = 3;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;

	// state register field positions
	localparam int STATE_LAMP = 16;
	localparam int STATE_FSM = 17;
	localparam int STATE_UNIT = 23;

	typedef enum logic [5:0] {
		S_START = 6'b000001,
		S_CMD = 6'b000010,
		S_UPLOAD = 6'b000100,
		S_CLEAR = 6'b001000,
		S_LOAD = 6'b010000,
		S_REFRESH = 6'b100000
	} fsm_type;

endpackage : loader_pkg

// [store_if.sv]
`timescale 1ns/1ps
interface store_if;
	logic we;
	logic [6:0] waddr;
	logic [15:0] wdata;
	logic [6:0] raddr;
	logic [15:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : store_if

// [settings_store.sv]
`timescale 1ns/1ps
module settings_store (
	input wire logic ref_clk,
	input wire logic rst,
	store_if.mem port
);
	import loader_pkg::*;

	typedef struct packed {
		logic [STORE_WORDS-1:0][15:0] mem;
		logic [15:0] rdata;
	} store_state_type;

	store_state_type r_reg;
	store_state_type r_next;

	always_comb begin
		r_next = r_reg;
		if (port.we && port.waddr < OFS_LAST + 7'h01) begin
			r_next.mem[port.waddr] = port.wdata;
		end
		// out of range reads answer zero rather than wrap
		if (port.raddr < OFS_LAST + 7'h01) begin
			r_next.rdata = r_reg.mem[port.raddr];
		end else begin
			r_next.rdata = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign port.rdata = r_reg.rdata;

endmodule : settings_store

// [setting_area_exchange_loader_sva.sv]
`timescale 1ns/1ps
module loader_checker
	import loader_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [6:0] unit_number,
	input wire logic [95:0] restart_bits,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic setting_error_lamp,
	input wire logic [15:0] error_offset
);
	logic [15:0] base;
	// unit kept below 96 by the bench, so no clamp is modelled here
	assign base = BASE_ADDR + 16'(unit_number) * BLOCK_WORDS;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	a_req_held: assert property (mem_req && !mem_ack && restart_bits == 96'h0
		|=> mem_req && $stable(mem_addr) && $stable(mem_wdata)) else $error("request dropped");
	a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("no idle cycle after ack");
	a_addr_window: assert property (mem_req
		|-> mem_addr >= base && mem_addr < base + BLOCK_WORDS) else $error("address outside block");
	a_lamp_offset: assert property (!setting_error_lamp |-> error_offset == 16'h0)
		else $error("offset without lamp");
	a_lamp_sticky: assert property (setting_error_lamp && restart_bits == 96'h0
		|=> setting_error_lamp) else $error("lamp lost without restart");
	a_offset_kept: assert property (setting_error_lamp
		|=> $stable(error_offset) || !setting_error_lamp) else $error("first offset overwritten");
	a_default_word: assert property (mem_req && mem_we && mem_addr != base + 16'h5a
		|-> mem_wdata == DEFAULT_WORD) else $error("bad upload word");
	a_err_word: assert property (mem_req && mem_we && mem_addr == base + 16'h5a
		|-> mem_wdata == error_offset) else $error("bad error word");
endmodule : loader_checker

// [host_model.sv]
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	input wire logic [3:0] lat,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [15:0] m [logic [15:0]];
	logic [3:0] cnt = 4'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0;
	// stale read data toggles so a late sample never matches by luck
	always @(posedge ref_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!mem_req || mem_ack) begin
			cnt <= 4'h0;
		end else if (cnt < lat) begin
			cnt <= cnt + 4'h1;
		end else begin
			mem_ack <= 1'b1;
			if (mem_we) m[mem_addr] = mem_wdata;
			else mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 16'h0;
		end
	end
endmodule : host_model

// [setting_area_exchange_loader_tb.sv]
`timescale 1ns/1ps
module setting_area_exchange_loader_tb;
	import loader_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq, mem_req, mem_we, mem_ack, setting_error_lamp;
	logic [31:0] hrdata, rv;
	logic [6:0] unit_number = 7'h02;
	logic [95:0] restart_bits = 96'h0;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, error_offset, b;
	logic [3:0] lat = 4'h0;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	setting_area_exchange_loader dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
		.unit_number, .restart_bits, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack, .setting_error_lamp, .error_offset);
	host_model host (.ref_clk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack);
	////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : xfer
	// held several cycles: only the rising edge may act
	task automatic restart();
		restart_bits[2] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		restart_bits[2] <= 1'b0;
	endtask : restart
	task automatic wait_wr90();
		do @(posedge ref_clk); while (!(mem_req && mem_we && mem_ack && mem_addr == b + 16'h5a));
	endtask : wait_wr90
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	////////////////////////////////////////
	initial begin
		b = BASE_ADDR + 16'h00c8;
		for (int i = 0; i < 100; i++) host.m[b + 16'(i)] = 16'h000a;
		host.m[b] = CMD_CLEAR;
		host.m[b + 16'h32] = 16'h8000;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		wait_wr90();
		chk("lamp", 1, setting_error_lamp);
		chk("offset", 32'h32, error_offset);
		chk("host error word", 32'h32, host.m[b + 16'h5a]);
		xfer(0, REG_LIMIT, 0);
		chk("limit", 32'h7fff, rv);
		xfer(0, 12'h204, 0);
		chk("store word", 32'ha, rv);
		xfer(0, 12'h100, 0);
		chk("unmapped", 0, rv);
		xfer(1, REG_MASK, 32'h4);
		repeat (2) @(negedge ref_clk);
		chk("irq", 1, irq);
		@(posedge ref_clk);
		xfer(1, REG_MASK, 32'h0);
		repeat (2) @(negedge ref_clk);
		chk("irq masked", 0, irq);
		@(posedge ref_clk);
		$display("test download done");
		host.m[b + 16'h32] = 16'h000a;
		lat <= 4'h3;
		restart();
		wait_wr90();
		chk("lamp cleared", 0, setting_error_lamp);
		xfer(0, REG_STATUS, 0);
		chk("restart seen", 32'h8, rv & 32'h8);
		xfer(1, REG_STATUS, 32'h8);
		xfer(0, REG_STATUS, 0);
		chk("status cleared", 0, rv & 32'h8);
		host.m[b + 16'h05] = 16'hffff;
		wait (setting_error_lamp === 1'b1);
		chk("group one offset", 32'h5, error_offset);
		@(posedge ref_clk);
		$display("test refresh done");
		host.m[b] = CMD_UPLOAD;
		host.m[b + 16'h05] = 16'h000a;
		restart();
		while (host.m[b] !== CMD_CLEAR) @(posedge ref_clk);
		for (int i = 1; i < 100; i++) chk("default", DEFAULT_WORD, host.m[b + 16'(i)]);
		chk("lamp after upload", 0, setting_error_lamp);
		xfer(0, REG_STATUS, 0);
		chk("upload done", 32'h1, rv & 32'h1);
		// clear every sticky bit so the next start load must set its own
		xfer(1, REG_STATUS, 32'hf);
		$display("test upload done");
		restart();
		wait_wr90();
		xfer(0, REG_STATUS, 0);
		chk("load done", 32'h2, rv & 32'h2);
		chk("command kept", CMD_CLEAR, host.m[b]);
		// host edits after start: only group one may follow them
		host.m[b + 16'h30] = 16'h0001;
		host.m[b + 16'h03] = 16'h0007;
		repeat (600) @(posedge ref_clk);
		xfer(0, 12'h2c0, 0);
		chk("group two once", 32'h0, rv);
		xfer(0, 12'h20c, 0);
		chk("group one refresh", 32'h7, rv);
		$display("test second start done");
		wrap_up();
	end
endmodule : setting_area_exchange_loader_tb

bind setting_area_exchange_loader loader_checker sva_i (.ref_clk(ref_clk), .rst(rst),
	.unit_number(unit_number), .restart_bits(restart_bits), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
	.setting_error_lamp(setting_error_lamp), .error_offset(error_offset));
